// ### vxr_pkg.sv
// Index map, field positions and reset values of the extension register bank.
package vxr_pkg;
    // Extension register indices.
    localparam logic [7:0] IDX_ROW_OFFSET_LOW = 8'h0d;
    localparam logic [7:0] IDX_TEXT_CURSOR = 8'h0e;
    localparam logic [7:0] IDX_SW_FLAGS0 = 8'h0f;
    localparam logic [7:0] IDX_LOW_MAP = 8'h10;
    localparam logic [7:0] IDX_HIGH_MAP = 8'h11;
    localparam logic [7:0] IDX_EMU_IRQ = 8'h14;
    localparam logic [7:0] IDX_WPROT = 8'h15;
    localparam logic [7:0] IDX_VOVF = 8'h16;
    localparam logic [7:0] IDX_HOVF = 8'h17;
    localparam logic [7:0] IDX_ALT_HDE = 8'h18;
    localparam logic [7:0] IDX_ALT_HSS = 8'h19;
    localparam logic [7:0] IDX_ALT_HSE = 8'h1a;
    localparam logic [7:0] IDX_ALT_HT = 8'h1b;
    localparam logic [7:0] IDX_ALT_HBS = 8'h1c;
    localparam logic [7:0] IDX_ALT_HBE = 8'h1d;
    // Writable-bit masks; cleared bits are reserved and read as zero.
    localparam logic [7:0] MASK_ROW_OFFSET_LOW = 8'h03;
    localparam logic [7:0] MASK_TEXT_CURSOR = 8'h8c;
    localparam logic [7:0] MASK_EMU_IRQ = 8'hf3;
    localparam logic [7:0] MASK_WPROT = 8'h7f;
    localparam logic [7:0] MASK_ALT_HSE = 8'h7f;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // Field positions.
    localparam int BIT_OFS_LSB = 0;
    localparam int BIT_ALT_OFS_LSB = 1;
    localparam int BIT_CURSOR_STEADY = 2;
    localparam int BIT_CURSOR_XOR = 3;
    localparam int BIT_SYNC_RST_IGNORE = 7;
    localparam int BIT_IRQ_DRIVE = 7;
    localparam int BIT_CRT_PROTECT = 7;
    localparam int BIT_DUAL_MAP = 1;
    localparam int NUM_WP_GROUPS = 7;
    localparam int WP_CRT_TIMING = 6;
    // Emulation mode codes and memory map codes.
    localparam logic [1:0] EMU_VGA = 2'h0;
    localparam logic [1:0] MAP_A0_64K = 2'h0;
    localparam logic [1:0] MAP_A0_32K = 2'h1;
    localparam logic [1:0] MAP_B0_32K = 2'h2;
    // CPU window bounds, address bits 19-15 (32 KB granules).
    localparam logic [4:0] WIN_A0 = 5'h14;
    localparam logic [4:0] WIN_A8 = 5'h15;
    localparam logic [4:0] WIN_B0 = 5'h16;
    localparam logic [4:0] WIN_B8 = 5'h17;
    // Stored-minus offsets of the alternate timing registers.
    localparam logic [8:0] ALT_TOTAL_BIAS = 9'h005;
    localparam logic [8:0] ALT_ONE_BIAS = 9'h001;
    localparam logic [4:0] SYNC_END_MASK = 5'h1f;
endpackage : vxr_pkg

// ### vxr_wprot_decode.sv
`timescale 1ns/1ps
// Decoder that turns write-protect bits into per-group write blocks.
module vxr_wprot_decode (
    // Protection state.
    input wire logic [7:0] wprot_i,
    input wire logic crt_protect_i,
    // Per-group blocks.
    output logic [6:0] block_o
);
    import vxr_pkg::*;

    // Each bit blocks its group; the timing group also honours the CRT bit.
    genvar g;
    generate
        for (g = 0; g < NUM_WP_GROUPS; g++) begin : g_grp
            if (g == WP_CRT_TIMING) begin : g_or
                assign block_o[g] = wprot_i[g] | crt_protect_i;
            end else begin : g_plain
                assign block_o[g] = wprot_i[g];
            end
        end
    endgenerate
endmodule : vxr_wprot_decode

// ### vxr_cpu_window.sv
`timescale 1ns/1ps
// CPU window decoder that picks the low or high map base for a host address.
module vxr_cpu_window (
    // Map configuration.
    input wire logic dual_i,
    input wire logic [1:0] map_sel_i,
    input wire logic [7:0] low_base_i,
    input wire logic [7:0] high_base_i,
    // Host address bits 19-15.
    input wire logic [4:0] addr_hi_i,
    // Result.
    output logic hit_o,
    output logic [7:0] base_o
);
    import vxr_pkg::*;

    logic in_low;
    logic in_high;

    // In dual mode only codes 00 and 01 make sense; other codes fall back to single mapping.
    always_comb begin
        in_low = 1'b0;
        in_high = 1'b0;
        case (map_sel_i)
            MAP_A0_64K: begin
                in_low = addr_hi_i == WIN_A0 || addr_hi_i == WIN_A8;
                in_high = dual_i && (addr_hi_i == WIN_B0 || addr_hi_i == WIN_B8);
            end
            MAP_A0_32K: begin
                in_low = addr_hi_i == WIN_A0;
                in_high = dual_i && addr_hi_i == WIN_A8;
            end
            MAP_B0_32K: begin
                in_low = addr_hi_i == WIN_B0;
            end
            default: begin
                in_low = addr_hi_i == WIN_B8;
            end
        endcase
        hit_o = in_low | in_high;
        base_o = in_high ? high_base_i : low_base_i;
    end
endmodule : vxr_cpu_window

// ### vxr_bank.sv
`timescale 1ns/1ps
// Indexed extension register bank with its decoded controls for the display controller.
// Operation
// - Offset LSB bits extend regular, alternate offsets
// - Cursor blinks when mode bit clear
// - Cursor style: replace or exclusive-OR
// - Bit 7 ignores sequencer synchronous reset
// - Software flags are plain storage
// - Low map gives base bits 17-10
// - Memory map code places low window
// - High map base for second window
// - Interrupt pin drive follows bit 7
// - Write-protect bits clear on reset, block writes
// - Bit 0 guards sequencer, graphics, attribute
// - Bits 1-3 guard CRT field subsets
// - Bit 4 misc/feature, bit 5 palette
// - Bit 6 ORed with CRT protect bit
// - Vertical overflow bits give bit 10
// - Horizontal overflow bits give high bits
// - Alternate display end in emulation only
// - Alternate sync start in uncompressed panel, emulation
// - Sync ends on low five bits match
// - Alternate total equals stored plus five
// - Panel width register in flat-panel modes
// - Same register is CRT alternate blank start
module vxr_bank (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Index/data port access from the host I/O decoder.
    input wire logic idx_wr_i,
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic [7:0] index_o,
    // Standard VGA context.
    input wire logic dual_map_i,
    input wire logic [1:0] map_sel_i,
    input wire logic [4:0] cpu_addr_hi_i,
    input wire logic seq_sync_reset_req_i,
    input wire logic crt_protect_i,
    input wire logic text_mode_i,
    input wire logic flat_panel_i,
    input wire logic hcompress_i,
    input wire logic graphics_emu_i,
    input wire logic irq_enable_i,
    input wire logic irq_active_i,
    input wire logic [4:0] char_count_low_i,
    // Offset and cursor controls.
    output logic row_offset_lsb_o,
    output logic alt_row_offset_lsb_o,
    output logic cursor_blink_o,
    output logic cursor_xor_o,
    output logic sync_reset_o,
    // Memory map.
    output logic cpu_window_hit_o,
    output logic [7:0] cpu_window_base_o,
    // Interrupt pin.
    output logic irq_o,
    output logic irq_oe_o,
    // Write-protect blocks, one per group.
    output logic [6:0] wprot_block_o,
    // Overflow bits.
    output logic [4:0] vert_bit10_o,
    output logic [3:0] horiz_bit8_o,
    output logic horiz_sync_end_bit5_o,
    output logic horiz_blank_end_bit6_o,
    output logic line_compare_hbit10_o,
    // Alternate horizontal timing.
    output logic use_alt_display_end_o,
    output logic [8:0] alt_display_end_o,
    output logic use_alt_sync_start_o,
    output logic [8:0] alt_sync_start_o,
    output logic alt_sync_end_hit_o,
    output logic [8:0] alt_total_o,
    output logic [8:0] panel_width_o,
    output logic use_alt_blank_start_o,
    output logic [8:0] alt_blank_start_o
);
    import vxr_pkg::*;

    logic [7:0] index_q;
    logic [7:0] row_ofs_q;
    logic [7:0] cursor_q;
    logic [7:0] flags0_q;
    logic [7:0] low_map_q;
    logic [7:0] high_map_q;
    logic [7:0] emu_q;
    logic [7:0] wprot_q;
    logic [7:0] vovf_q;
    logic [7:0] hovf_q;
    logic [7:0] alt_hde_q;
    logic [7:0] alt_hss_q;
    logic [7:0] alt_hse_q;
    logic [7:0] alt_ht_q;
    logic [7:0] alt_hbs_q;
    logic [7:0] alt_hbe_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic [6:0] block_d;
    logic win_hit_d;
    logic [7:0] win_base_d;
    logic emu_mode;

    // Index latch; any index may be written, unknown ones read as zero.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            index_q <= RESET_VAL;
        end else if (idx_wr_i) begin
            index_q <= wdata_i;
        end
    end

    // Writes always land; protection gates only the standard groups outside.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            row_ofs_q <= RESET_VAL;
            cursor_q <= RESET_VAL;
            flags0_q <= RESET_VAL;
            low_map_q <= RESET_VAL;
            high_map_q <= RESET_VAL;
            emu_q <= RESET_VAL;
            wprot_q <= RESET_VAL;
            vovf_q <= RESET_VAL;
            hovf_q <= RESET_VAL;
            alt_hde_q <= RESET_VAL;
            alt_hss_q <= RESET_VAL;
            alt_hse_q <= RESET_VAL;
            alt_ht_q <= RESET_VAL;
            alt_hbs_q <= RESET_VAL;
            alt_hbe_q <= RESET_VAL;
        end else if (data_wr_i) begin
            case (index_q)
                IDX_ROW_OFFSET_LOW: row_ofs_q <= wdata_i & MASK_ROW_OFFSET_LOW;
                IDX_TEXT_CURSOR: cursor_q <= wdata_i & MASK_TEXT_CURSOR;
                IDX_SW_FLAGS0: flags0_q <= wdata_i;
                IDX_LOW_MAP: low_map_q <= wdata_i;
                IDX_HIGH_MAP: high_map_q <= wdata_i;
                IDX_EMU_IRQ: emu_q <= wdata_i & MASK_EMU_IRQ;
                IDX_WPROT: wprot_q <= wdata_i & MASK_WPROT;
                IDX_VOVF: vovf_q <= wdata_i;
                IDX_HOVF: hovf_q <= wdata_i;
                IDX_ALT_HDE: alt_hde_q <= wdata_i;
                IDX_ALT_HSS: alt_hss_q <= wdata_i;
                IDX_ALT_HSE: alt_hse_q <= wdata_i & MASK_ALT_HSE;
                IDX_ALT_HT: alt_ht_q <= wdata_i;
                IDX_ALT_HBS: alt_hbs_q <= wdata_i;
                IDX_ALT_HBE: alt_hbe_q <= wdata_i;
                default: begin
                end
            endcase
        end
    end

    // Read mux; reads are never affected by protection.
    always_comb begin
        case (index_q)
            IDX_ROW_OFFSET_LOW: rdata_d = row_ofs_q;
            IDX_TEXT_CURSOR: rdata_d = cursor_q;
            IDX_SW_FLAGS0: rdata_d = flags0_q;
            IDX_LOW_MAP: rdata_d = low_map_q;
            IDX_HIGH_MAP: rdata_d = high_map_q;
            IDX_EMU_IRQ: rdata_d = emu_q;
            IDX_WPROT: rdata_d = wprot_q;
            IDX_VOVF: rdata_d = vovf_q;
            IDX_HOVF: rdata_d = hovf_q;
            IDX_ALT_HDE: rdata_d = alt_hde_q;
            IDX_ALT_HSS: rdata_d = alt_hss_q;
            IDX_ALT_HSE: rdata_d = alt_hse_q;
            IDX_ALT_HT: rdata_d = alt_ht_q;
            IDX_ALT_HBS: rdata_d = alt_hbs_q;
            IDX_ALT_HBE: rdata_d = alt_hbe_q;
            default: rdata_d = RESET_VAL;
        endcase
    end

    // Read data is captured on the strobe and holds steady for the host.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= RESET_VAL;
        end else if (data_rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    // Write-protect decode and CPU window decode.
    vxr_wprot_decode u_wprot (
        .wprot_i(wprot_q),
        .crt_protect_i(crt_protect_i),
        .block_o(block_d)
    );

    vxr_cpu_window u_win (
        .dual_i(dual_map_i),
        .map_sel_i(map_sel_i),
        .low_base_i(low_map_q),
        .high_base_i(high_map_q),
        .addr_hi_i(cpu_addr_hi_i),
        .hit_o(win_hit_d),
        .base_o(win_base_d)
    );

    assign emu_mode = emu_q[1:0] != EMU_VGA;

    // Text, map and protection controls, registered so every output is a flop.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            row_offset_lsb_o <= 1'b0;
            alt_row_offset_lsb_o <= 1'b0;
            cursor_blink_o <= 1'b0;
            cursor_xor_o <= 1'b0;
            sync_reset_o <= 1'b0;
            cpu_window_hit_o <= 1'b0;
            cpu_window_base_o <= RESET_VAL;
            wprot_block_o <= '0;
        end else begin
            row_offset_lsb_o <= row_ofs_q[BIT_OFS_LSB];
            alt_row_offset_lsb_o <= row_ofs_q[BIT_ALT_OFS_LSB];
            cursor_blink_o <= text_mode_i && !cursor_q[BIT_CURSOR_STEADY];
            cursor_xor_o <= text_mode_i && cursor_q[BIT_CURSOR_XOR];
            sync_reset_o <= seq_sync_reset_req_i && !cursor_q[BIT_SYNC_RST_IGNORE];
            cpu_window_hit_o <= win_hit_d;
            cpu_window_base_o <= win_base_d;
            wprot_block_o <= block_d;
        end
    end

    // Interrupt pin: floats unless bit 7 is set and the interrupt is enabled.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
            irq_oe_o <= 1'b0;
        end else begin
            irq_oe_o <= emu_q[BIT_IRQ_DRIVE] && irq_enable_i;
            irq_o <= emu_q[BIT_IRQ_DRIVE] && irq_enable_i && irq_active_i;
        end
    end

    // Overflow bits feed the high bits of the normal timing; the alternate values take none of them.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vert_bit10_o <= '0;
            horiz_bit8_o <= '0;
            horiz_sync_end_bit5_o <= 1'b0;
            horiz_blank_end_bit6_o <= 1'b0;
            line_compare_hbit10_o <= 1'b0;
        end else begin
            vert_bit10_o <= {vovf_q[6], vovf_q[4], vovf_q[2], vovf_q[1], vovf_q[0]};
            horiz_bit8_o <= {hovf_q[4], hovf_q[2], hovf_q[1], hovf_q[0]};
            horiz_sync_end_bit5_o <= hovf_q[3];
            horiz_blank_end_bit6_o <= hovf_q[5];
            line_compare_hbit10_o <= hovf_q[6];
        end
    end

    // Stored values are biased; counts are rebuilt at nine bits to keep the carry.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            use_alt_display_end_o <= 1'b0;
            alt_display_end_o <= '0;
            use_alt_sync_start_o <= 1'b0;
            alt_sync_start_o <= '0;
            alt_sync_end_hit_o <= 1'b0;
            alt_total_o <= '0;
            panel_width_o <= '0;
            use_alt_blank_start_o <= 1'b0;
            alt_blank_start_o <= '0;
        end else begin
            use_alt_display_end_o <= emu_mode;
            alt_display_end_o <= {1'b0, alt_hde_q} + ALT_ONE_BIAS;
            use_alt_sync_start_o <= (flat_panel_i && !hcompress_i) || graphics_emu_i;
            alt_sync_start_o <= {1'b0, alt_hss_q} + ALT_ONE_BIAS;
            alt_sync_end_hit_o <= char_count_low_i == (alt_hse_q[4:0] & SYNC_END_MASK);
            alt_total_o <= {1'b0, alt_ht_q} + ALT_TOTAL_BIAS;
            // Double-drive panels need an even width; software keeps to that.
            panel_width_o <= flat_panel_i ? {1'b0, alt_hbs_q} + ALT_ONE_BIAS : '0;
            use_alt_blank_start_o <= !flat_panel_i && graphics_emu_i;
            alt_blank_start_o <= {1'b0, alt_hbs_q} + ALT_ONE_BIAS;
        end
    end

    assign rdata_o = rdata_q;
    assign index_o = index_q;
endmodule : vxr_bank

// ### vxr_bank_assertions.sv
`timescale 1ns/1ps
// Concurrent checks on the ports of the extension register bank.
module vxr_bank_assertions
    import vxr_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Register access.
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] index_o,
    // Context inputs.
    input wire logic seq_sync_reset_req_i,
    input wire logic crt_protect_i,
    input wire logic text_mode_i,
    input wire logic flat_panel_i,
    input wire logic hcompress_i,
    input wire logic graphics_emu_i,
    input wire logic irq_enable_i,
    input wire logic irq_active_i,
    input wire logic [4:0] char_count_low_i,
    // Watched outputs.
    input wire logic cursor_blink_o,
    input wire logic cursor_xor_o,
    input wire logic sync_reset_o,
    input wire logic irq_o,
    input wire logic irq_oe_o,
    input wire logic [6:0] wprot_block_o,
    input wire logic use_alt_sync_start_o,
    input wire logic alt_sync_end_hit_o,
    input wire logic use_alt_blank_start_o
);
    logic up_q;
    logic [7:0] tc_q, emu_q, wp_q, hse_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    // Outputs lag a cycle, so the first edge after release is skipped.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
        end
    end

    // Shadows of the registers the checks use.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tc_q <= RESET_VAL;
            emu_q <= RESET_VAL;
            wp_q <= RESET_VAL;
            hse_q <= RESET_VAL;
        end else if (data_wr_i) begin
            case (index_o)
                IDX_TEXT_CURSOR: tc_q <= wdata_i & MASK_TEXT_CURSOR;
                IDX_EMU_IRQ: emu_q <= wdata_i & MASK_EMU_IRQ;
                IDX_WPROT: wp_q <= wdata_i & MASK_WPROT;
                IDX_ALT_HSE: hse_q <= wdata_i & MASK_ALT_HSE;
                default: ;
            endcase
        end
    end

    // Accesses to the protection register.
    sequence s_wr_wprot;
        data_wr_i && index_o == IDX_WPROT;
    endsequence
    sequence s_rd_wprot;
        data_rd_i && !data_wr_i && index_o == IDX_WPROT;
    endsequence

    a_cursor_blink: assert property (
        up_q |-> cursor_blink_o == ($past(text_mode_i) && !$past(tc_q[BIT_CURSOR_STEADY])))
        else $error("cursor blink wrong");
    a_cursor_style: assert property (
        up_q |-> cursor_xor_o == ($past(text_mode_i) && $past(tc_q[BIT_CURSOR_XOR])))
        else $error("cursor style wrong");
    a_sync_ignore: assert property (
        up_q |-> sync_reset_o == ($past(seq_sync_reset_req_i) && !$past(tc_q[7])))
        else $error("sync reset not gated");
    a_irq_drive: assert property (
        up_q |-> irq_oe_o == ($past(emu_q[BIT_IRQ_DRIVE]) && $past(irq_enable_i))
            && irq_o == ($past(emu_q[7]) && $past(irq_enable_i) && $past(irq_active_i)))
        else $error("interrupt drive wrong");
    a_wprot_write: assert property (
        s_wr_wprot ##2 1'b1 |-> wprot_block_o[5:0] == $past(wdata_i[5:0], 2))
        else $error("protect blocks wrong");
    a_crt_protect_or: assert property (
        up_q |-> wprot_block_o[6] == ($past(wp_q[WP_CRT_TIMING]) || $past(crt_protect_i)))
        else $error("timing block not ORed");
    a_wprot_read: assert property (
        s_rd_wprot |=> rdata_o == $past(wp_q))
        else $error("protect read-back wrong");
    a_sync_end_hit: assert property (
        up_q |-> alt_sync_end_hit_o == ($past(char_count_low_i) == $past(hse_q[4:0])))
        else $error("sync end match wrong");
    a_alt_sync_sel: assert property (
        up_q |-> use_alt_sync_start_o
            == (($past(flat_panel_i) && !$past(hcompress_i)) || $past(graphics_emu_i)))
        else $error("sync start select wrong");
    a_blank_sel: assert property (
        up_q |-> use_alt_blank_start_o == (!$past(flat_panel_i) && $past(graphics_emu_i)))
        else $error("blank start select wrong");
endmodule : vxr_bank_assertions

bind vxr_bank vxr_bank_assertions i_chk (
    .core_clk_i, .arst_n_i, .data_wr_i, .data_rd_i, .wdata_i, .rdata_o, .index_o,
    .seq_sync_reset_req_i, .crt_protect_i, .text_mode_i, .flat_panel_i, .hcompress_i,
    .graphics_emu_i, .irq_enable_i, .irq_active_i, .char_count_low_i, .cursor_blink_o,
    .cursor_xor_o, .sync_reset_o, .irq_o, .irq_oe_o, .wprot_block_o, .use_alt_sync_start_o,
    .alt_sync_end_hit_o, .use_alt_blank_start_o
);

// ### vxr_bank_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the extension register bank.
module vxr_bank_bench;
    import vxr_pkg::*;
    logic core_clk_i = 1'b0, arst_n_i = 1'b0, idx_wr_i = 1'b0, data_wr_i = 1'b0;
    logic data_rd_i = 1'b0, dual_map_i = 1'b0, seq_sync_reset_req_i = 1'b0;
    logic crt_protect_i = 1'b0, text_mode_i = 1'b0, flat_panel_i = 1'b0, hcompress_i = 1'b0;
    logic graphics_emu_i = 1'b0, irq_enable_i = 1'b0, irq_active_i = 1'b0;
    logic [1:0] map_sel_i = 2'h0;
    logic [4:0] cpu_addr_hi_i = 5'h00, char_count_low_i = 5'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o, index_o, cpu_window_base_o, rv;
    logic row_offset_lsb_o, alt_row_offset_lsb_o, cursor_blink_o, cursor_xor_o, sync_reset_o;
    logic cpu_window_hit_o, irq_o, irq_oe_o, horiz_sync_end_bit5_o, horiz_blank_end_bit6_o;
    logic line_compare_hbit10_o, use_alt_display_end_o, use_alt_sync_start_o;
    logic alt_sync_end_hit_o, use_alt_blank_start_o;
    logic [3:0] horiz_bit8_o;
    logic [4:0] vert_bit10_o;
    logic [6:0] wprot_block_o;
    logic [8:0] alt_display_end_o, alt_sync_start_o, alt_total_o, panel_width_o;
    logic [8:0] alt_blank_start_o;
    int err_total = 0;
    int tests_run = 0;
    // Index and mask per register, plus an unmapped index that reads zero.
    localparam logic [15:0] REG_TAB [16] = '{
        {IDX_ROW_OFFSET_LOW, MASK_ROW_OFFSET_LOW}, {IDX_TEXT_CURSOR, MASK_TEXT_CURSOR},
        {IDX_SW_FLAGS0, MASK_FULL}, {IDX_LOW_MAP, MASK_FULL}, {IDX_HIGH_MAP, MASK_FULL},
        {IDX_EMU_IRQ, MASK_EMU_IRQ}, {IDX_WPROT, MASK_WPROT}, {IDX_VOVF, MASK_FULL},
        {IDX_HOVF, MASK_FULL}, {IDX_ALT_HDE, MASK_FULL}, {IDX_ALT_HSS, MASK_FULL},
        {IDX_ALT_HSE, MASK_ALT_HSE}, {IDX_ALT_HT, MASK_FULL}, {IDX_ALT_HBS, MASK_FULL},
        {IDX_ALT_HBE, MASK_FULL}, {8'h12, 8'h00}};
    // Window cases as dual, map code, address bits 19-15, then hit and high-map flags.
    localparam logic [19:0] MAP_TAB [14] = '{
        20'h00142, 20'h00152, 20'h00160, 20'h01142, 20'h01150, 20'h02162, 20'h02170,
        20'h03172, 20'h10152, 20'h10163, 20'h10173, 20'h11153, 20'h11142, 20'h11160};

    vxr_bank i_dut (
        .core_clk_i, .arst_n_i, .idx_wr_i, .data_wr_i, .data_rd_i, .wdata_i, .rdata_o,
        .index_o, .dual_map_i, .map_sel_i, .cpu_addr_hi_i, .seq_sync_reset_req_i,
        .crt_protect_i, .text_mode_i, .flat_panel_i, .hcompress_i, .graphics_emu_i,
        .irq_enable_i, .irq_active_i, .char_count_low_i, .row_offset_lsb_o,
        .alt_row_offset_lsb_o, .cursor_blink_o, .cursor_xor_o, .sync_reset_o,
        .cpu_window_hit_o, .cpu_window_base_o, .irq_o, .irq_oe_o, .wprot_block_o,
        .vert_bit10_o, .horiz_bit8_o, .horiz_sync_end_bit5_o, .horiz_blank_end_bit6_o,
        .line_compare_hbit10_o, .use_alt_display_end_o, .alt_display_end_o,
        .use_alt_sync_start_o, .alt_sync_start_o, .alt_sync_end_hit_o, .alt_total_o,
        .panel_width_o, .use_alt_blank_start_o, .alt_blank_start_o
    );

    // Verdict; the watchdog ends here too.
    task automatic end_of_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [8:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Index cycle; the data strobe uses the index latched one edge earlier.
    task automatic put_idx(input logic [7:0] idx);
        @(posedge core_clk_i);
        idx_wr_i <= 1'b1;
        wdata_i <= idx;
        @(posedge core_clk_i);
        idx_wr_i <= 1'b0;
    endtask : put_idx

    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        put_idx(idx);
        data_wr_i <= 1'b1;
        wdata_i <= val;
        @(posedge core_clk_i);
        data_wr_i <= 1'b0;
    endtask : wr

    // Read data is registered on the strobe edge and taken just after it.
    task automatic rd(input logic [7:0] idx, output logic [7:0] val);
        put_idx(idx);
        data_rd_i <= 1'b1;
        @(posedge core_clk_i);
        data_rd_i <= 1'b0;
        #1 val = rdata_o;
    endtask : rd

    // Decoded outputs settle one edge after a change; waiting two edges leaves margin.
    task automatic settle();
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask : settle

    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_total++;
        end_of_test();
    end

    initial begin
        logic [7:0] v;
        logic [19:0] t;
        repeat (10) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        // Reset values, then all ones, a pattern and zero read back.
        for (int p = 0; p < 4; p++) begin
            v = (p == 1) ? 8'hff : ((p == 2) ? 8'ha5 : 8'h00);
            for (int r = 0; r < 16; r++) begin
                if (p > 0) wr(REG_TAB[r][15:8], v);
                rd(REG_TAB[r][15:8], rv);
                chk("index", index_o, REG_TAB[r][15:8]);
                chk($sformatf("reg_%h", REG_TAB[r][15:8]), rv, v & REG_TAB[r][7:0]);
            end
        end
        for (int i = 1; i < 3; i++) begin
            wr(IDX_ROW_OFFSET_LOW, 8'(i));
            settle();
            chk("row_lsb", row_offset_lsb_o, i[0]);
            chk("alt_row_lsb", alt_row_offset_lsb_o, i[1]);
        end
        // Cursor and sync reset over text mode and control bits.
        for (int i = 0; i < 4; i++) begin
            wr(IDX_TEXT_CURSOR, i[1] ? 8'h8c : 8'h00);
            text_mode_i <= i[0];
            seq_sync_reset_req_i <= i[0];
            settle();
            chk("cursor_blink", cursor_blink_o, i[0] & ~i[1]);
            chk("cursor_xor", cursor_xor_o, i[0] & i[1]);
            chk("sync_reset", sync_reset_o, i[0] & ~i[1]);
        end
        // Interrupt pin states and emulation codes.
        for (int i = 0; i < 8; i++) begin
            wr(IDX_EMU_IRQ, {i[2], 5'h00, i[1:0]});
            irq_enable_i <= i[1];
            irq_active_i <= i[0];
            settle();
            chk("irq_oe", irq_oe_o, i[2] & i[1]);
            chk("irq", irq_o, i[2] & i[1] & i[0]);
            chk("use_alt_de", use_alt_display_end_o, i[1:0] != 2'h0);
        end
        // One group at a time, then the standard CRT protect bit alone.
        for (int g = 0; g < 8; g++) begin
            wr(IDX_WPROT, (g == 7) ? 8'h00 : 8'(1 << g));
            crt_protect_i <= (g == 7);
            settle();
            chk("wprot", wprot_block_o, (g == 7) ? 9'h040 : 9'(1 << g));
        end
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'haa : 8'h55;
            wr(IDX_VOVF, v);
            wr(IDX_HOVF, v);
            settle();
            chk("vert_bit10", vert_bit10_o, {v[6], v[4], v[2], v[1], v[0]});
            chk("horiz_bit8", horiz_bit8_o, {v[4], v[2], v[1], v[0]});
            chk("hse_bit5", horiz_sync_end_bit5_o, v[3]);
            chk("hbe_bit6", horiz_blank_end_bit6_o, v[5]);
            chk("lc_bit10", line_compare_hbit10_o, v[6]);
        end
        wr(IDX_ALT_HDE, 8'hff);
        wr(IDX_ALT_HSS, 8'h4f);
        wr(IDX_ALT_HSE, 8'h13);
        wr(IDX_ALT_HT, 8'hfe);
        wr(IDX_ALT_HBS, 8'h4f);
        settle();
        chk("alt_de", alt_display_end_o, 9'h100);
        chk("alt_ss", alt_sync_start_o, 9'h050);
        chk("alt_total", alt_total_o, 9'h103);
        chk("alt_bs", alt_blank_start_o, 9'h050);
        // Panel, compression and emulation; the count matches at i of 3.
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk_i);
            flat_panel_i <= i[2];
            hcompress_i <= i[1];
            graphics_emu_i <= i[0];
            char_count_low_i <= 5'(5'h10 + i);
            settle();
            chk("use_alt_ss", use_alt_sync_start_o, (i[2] & ~i[1]) | i[0]);
            chk("use_alt_bs", use_alt_blank_start_o, ~i[2] & i[0]);
            chk("panel_width", panel_width_o, i[2] ? 9'h050 : 9'h000);
            chk("sync_end_hit", alt_sync_end_hit_o, i == 3);
        end
        wr(IDX_LOW_MAP, 8'h21);
        wr(IDX_HIGH_MAP, 8'h42);
        for (int i = 0; i < 14; i++) begin
            t = MAP_TAB[i];
            @(posedge core_clk_i);
            dual_map_i <= t[16];
            map_sel_i <= t[13:12];
            cpu_addr_hi_i <= t[8:4];
            settle();
            chk($sformatf("win_hit_%0d", i), cpu_window_hit_o, t[1]);
            if (t[1]) chk("win_base", cpu_window_base_o, t[0] ? 9'h042 : 9'h021);
        end
        end_of_test();
    end
endmodule : vxr_bank_bench
